// ==== rtl/ckd_pkg.sv ====
// Package: offsets, field layout, reset values and decoded-value types for the clock config
package ckd_pkg;

   // ---------------------------------------------------------------
   // Register offsets on the control port
   // ---------------------------------------------------------------
   localparam logic [7:0] CKD_OFS_PLL_MULT_LOW = 8'h38;   // Multiplier low byte
   localparam logic [7:0] CKD_OFS_N_DENSITY    = 8'h39;   // N and density divider
   localparam logic [7:0] CKD_OFS_M_DIV        = 8'h3a;   // M divider
   localparam logic [7:0] CKD_OFS_MOD_BITCLK   = 8'h3b;   // Modulator / bit-clock tops
   localparam logic [7:0] CKD_OFS_PRI_BDIV_LOW = 8'h3c;   // Primary bit-clock low byte

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CKD_RST_PLL_MULT_LOW = 8'h08;
   localparam logic [7:0] CKD_RST_N_DENSITY    = 8'h20;
   localparam logic [7:0] CKD_RST_M_DIV        = 8'h04;
   localparam logic [7:0] CKD_RST_MOD_BITCLK   = 8'h00;
   localparam logic [7:0] CKD_RST_PRI_BDIV_LOW = 8'h01;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CKD_N_DIV_MSB     = 7;
   localparam int CKD_N_DIV_LSB     = 5;
   localparam int CKD_DENSITY_MSB   = 4;
   localparam int CKD_DENSITY_LSB   = 2;
   localparam int CKD_M_DIV_MSB     = 7;
   localparam int CKD_M_DIV_LSB     = 2;
   localparam int CKD_MOD_DIV_MSB   = 5;
   localparam int CKD_MOD_DIV_LSB   = 4;
   localparam int CKD_PRI_TOP_BIT   = 2;
   localparam int CKD_SEC_TOP_BIT   = 1;
   localparam int CKD_RO_ZERO_BIT   = 0;

   // Writable mask of the modulator / bit-clock register (bit 0 is read-only)
   localparam logic [7:0] CKD_MOD_BITCLK_WMASK = 8'hfe;

   // ---------------------------------------------------------------
   // Decoded divide / multiply values for zero codes and reserved limits
   // ---------------------------------------------------------------
   localparam logic [3:0] CKD_N_ZERO_VALUE     = 4'h8;
   localparam logic [6:0] CKD_M_ZERO_VALUE     = 7'h40;
   localparam logic [9:0] CKD_BDIV_ZERO_VALUE  = 10'h200;
   localparam logic [2:0] CKD_DENSITY_MAX_CODE = 3'h4;
   localparam logic [1:0] CKD_MOD_RSVD_CODE    = 2'h3;

   // ---------------------------------------------------------------
   // Decoded settings handed to the PLL and divider chain
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [8:0] pllMult;       // Integer multiplier, 0..511; reserved zero passes through
      logic [3:0] n_divider;          // N divide ratio, 1..8
      logic [4:0] densityDiv;    // Density modulator divide ratio, 1..16
      logic [6:0] m_divider;          // M divide ratio, 1..64
      logic [2:0] modDiv;        // Modulator clock divide ratio, 1/2/4
      logic [9:0] priBitclkDiv;  // Primary bit-clock divide ratio, 1..512
   } ckd_div_cfg_t;

   // Control port request
   typedef struct packed {
      logic       wrEn;          // One-cycle write strobe
      logic       rdEn;          // One-cycle read strobe
      logic [7:0] addr;          // Register offset
      logic [7:0] wrData;        // Write data
   } ckd_reg_req_t;

endpackage

// ==== rtl/ckd_clock_cfg.sv ====
// Clock tree configuration registers and divider value decoding
`timescale 1ns/10ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module ckd_clock_cfg
   import ckd_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire ckd_reg_req_t regReq,
   output      logic [7:0]   regRdData,
   input  wire logic         pllIntMultTopBit,
   input  wire logic         autoDetectEn,
   input  wire ckd_div_cfg_t autoCfg,
   input  wire logic         nDividerEnable,
   input  wire logic         mDividerEnable,
   input  wire logic         densityModDividerEnable,
   output      ckd_div_cfg_t divCfg,
   output      logic         secondaryBitclkDivTop,
   output      logic         nDividerActive,
   output      logic         mDividerActive,
   output      logic         densityDividerActive,
   output      logic         reservedCodeSeen
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ---------------------------------------------------------------
   // Decode functions
   // ---------------------------------------------------------------

   // Zero code means eight
   function automatic logic [3:0] decN(input logic [2:0] code);
      decN = (code == 3'h0) ? CKD_N_ZERO_VALUE : {1'b0, code};
   endfunction

   // Power-of-two ratio; reserved codes fall back to one
   function automatic logic [4:0] decDensity(input logic [2:0] code);
      decDensity = (code > CKD_DENSITY_MAX_CODE) ? 5'h01 : 5'(5'h01 << code);
   endfunction

   // Zero code means sixty-four
   function automatic logic [6:0] decM(input logic [5:0] code);
      decM = (code == 6'h00) ? CKD_M_ZERO_VALUE : {1'b0, code};
   endfunction

   // Reserved code three falls back to one
   function automatic logic [2:0] decMod(input logic [1:0] code);
      decMod = (code == CKD_MOD_RSVD_CODE) ? 3'h1 : 3'(3'h1 << code);
   endfunction

   // Zero code means 512
   function automatic logic [9:0] decBdiv(input logic [8:0] code);
      decBdiv = (code == 9'h000) ? CKD_BDIV_ZERO_VALUE : {1'b0, code};
   endfunction

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [7:0]   multLow_reg;        // Multiplier low byte
   logic [7:0]   nDensity_reg;       // N and density fields
   logic [7:0]   m_divider_reg;           // M field
   logic [7:0]   modBitclk_reg;      // Modulator and bit-clock tops
   logic [7:0]   priBdivLow_reg;     // Primary bit-clock low byte
   logic [8:0]   multCode;           // Joined multiplier code
   logic [8:0]   priBdivCode;        // Joined primary bit-clock code
   ckd_div_cfg_t progCfg;            // Settings decoded from registers
   ckd_div_cfg_t divCfg_next;        // Settings chosen for the chain
   logic         reservedCode;       // Some field holds a reserved code

   wire wrHit = regReq.wrEn;

   // Write path: single-cycle strobe, all bits of a register land together
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         multLow_reg    <= CKD_RST_PLL_MULT_LOW;
         nDensity_reg   <= CKD_RST_N_DENSITY;
         m_divider_reg       <= CKD_RST_M_DIV;
         modBitclk_reg  <= CKD_RST_MOD_BITCLK;
         priBdivLow_reg <= CKD_RST_PRI_BDIV_LOW;
      end
      else if (wrHit)
      begin
         // Reserved bits stay writable storage; software keeps them at reset
         if (regReq.addr == CKD_OFS_PLL_MULT_LOW)
         begin
            multLow_reg <= regReq.wrData;
         end
         else if (regReq.addr == CKD_OFS_N_DENSITY)
         begin
            nDensity_reg <= regReq.wrData;
         end
         else if (regReq.addr == CKD_OFS_M_DIV)
         begin
            m_divider_reg <= regReq.wrData;
         end
         else if (regReq.addr == CKD_OFS_MOD_BITCLK)
         begin
            // Read-only bit is masked away from the write
            modBitclk_reg <= regReq.wrData & CKD_MOD_BITCLK_WMASK;
         end
         else if (regReq.addr == CKD_OFS_PRI_BDIV_LOW)
         begin
            priBdivLow_reg <= regReq.wrData;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------

   // Registered read data; unmapped offsets return zero
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         regRdData <= 8'h00;
      end
      else if (regReq.rdEn)
      begin
         if (regReq.addr == CKD_OFS_PLL_MULT_LOW)
         begin
            regRdData <= multLow_reg;
         end
         else if (regReq.addr == CKD_OFS_N_DENSITY)
         begin
            regRdData <= nDensity_reg;
         end
         else if (regReq.addr == CKD_OFS_M_DIV)
         begin
            regRdData <= m_divider_reg;
         end
         else if (regReq.addr == CKD_OFS_MOD_BITCLK)
         begin
            regRdData <= modBitclk_reg & CKD_MOD_BITCLK_WMASK;
         end
         else if (regReq.addr == CKD_OFS_PRI_BDIV_LOW)
         begin
            regRdData <= priBdivLow_reg;
         end
         else
         begin
            regRdData <= 8'h00;
         end
      end
   end

   // ---------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------

   // Multiplier top bit comes from a register owned elsewhere; bit-clock top bit from the modulator register
   assign multCode    = {pllIntMultTopBit, multLow_reg};
   assign priBdivCode = {modBitclk_reg[CKD_PRI_TOP_BIT], priBdivLow_reg};

   // Decode from stored registers only, so a half-written value never shows
   always_comb
   begin
      progCfg.pllMult      = multCode;
      progCfg.n_divider         = decN(nDensity_reg[CKD_N_DIV_MSB:CKD_N_DIV_LSB]);
      progCfg.densityDiv   = decDensity(nDensity_reg[CKD_DENSITY_MSB:CKD_DENSITY_LSB]);
      progCfg.m_divider         = decM(m_divider_reg[CKD_M_DIV_MSB:CKD_M_DIV_LSB]);
      progCfg.modDiv       = decMod(modBitclk_reg[CKD_MOD_DIV_MSB:CKD_MOD_DIV_LSB]);
      progCfg.priBitclkDiv = decBdiv(priBdivCode);
   end

   // Auto detection wins over anything programmed
   assign divCfg_next = autoDetectEn ? autoCfg : progCfg;

   // Reserved codes are flagged, not trapped; density and modulator fall back to one, a zero multiplier passes through
   assign reservedCode = (multCode == 9'h000)
                       | (nDensity_reg[CKD_DENSITY_MSB:CKD_DENSITY_LSB] > CKD_DENSITY_MAX_CODE)
                       | (modBitclk_reg[CKD_MOD_DIV_MSB:CKD_MOD_DIV_LSB] == CKD_MOD_RSVD_CODE);

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------

   // Settings move one edge after the register write completes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCfg <= '0;
      end
      else
      begin
         divCfg <= divCfg_next;
      end
   end

   // Secondary top bit passed on for the other bit-clock divider
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         secondaryBitclkDivTop <= 1'b0;
      end
      else
      begin
         secondaryBitclkDivTop <= modBitclk_reg[CKD_SEC_TOP_BIT];
      end
   end

   // Divider enables; each divider idles until its bit is one
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nDividerActive       <= 1'b0;
         mDividerActive       <= 1'b0;
         densityDividerActive <= 1'b0;
      end
      else
      begin
         nDividerActive       <= nDividerEnable;
         mDividerActive       <= mDividerEnable;
         densityDividerActive <= densityModDividerEnable;
      end
   end

   // Reserved-code indicator; ignored while auto detection drives the chain
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reservedCodeSeen <= 1'b0;
      end
      else
      begin
         reservedCodeSeen <= reservedCode & ~autoDetectEn;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic firstCycle_reg;   // High in the first cycle after reset release
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         firstCycle_reg <= 1'b1;
      end
      else
      begin
         firstCycle_reg <= 1'b0;
      end
   end

   property p_mult_join;
      rst_n && !autoDetectEn |=> divCfg.pllMult == $past({pllIntMultTopBit, multLow_reg});
   endproperty
   a_mult_join: assert property (p_mult_join) else $error("multiplier join wrong");

   property p_mult_reset;
      firstCycle_reg |-> multLow_reg == 8'h08;
   endproperty
   a_mult_reset: assert property (p_mult_reset) else $error("multiplier reset wrong");

   property p_auto;
      rst_n && autoDetectEn |=> divCfg == $past(autoCfg);
   endproperty
   a_auto: assert property (p_auto) else $error("auto settings not used");

   property p_n_zero;
      !autoDetectEn && nDensity_reg[7:5] == 3'h0 |=> divCfg.n_divider == 4'h8;
   endproperty
   a_n_zero: assert property (p_n_zero) else $error("N zero not eight");

   property p_density;
      !autoDetectEn && nDensity_reg[4:2] == 3'h4 |=> divCfg.densityDiv == 5'h10;
   endproperty
   a_density: assert property (p_density) else $error("density ratio wrong");

   property p_m_zero;
      !autoDetectEn && m_divider_reg[7:2] == 6'h00 |=> divCfg.m_divider == 7'h40;
   endproperty
   a_m_zero: assert property (p_m_zero) else $error("M zero not 64");

   property p_mod;
      !autoDetectEn && modBitclk_reg[5:4] == 2'h2 |=> divCfg.modDiv == 3'h4;
   endproperty
   a_mod: assert property (p_mod) else $error("modulator ratio wrong");

   property p_bdiv_zero;
      !autoDetectEn && priBdivLow_reg == 8'h00 && !modBitclk_reg[2]
         |=> divCfg.priBitclkDiv == 10'h200;
   endproperty
   a_bdiv_zero: assert property (p_bdiv_zero) else $error("bit-clock zero not 512");

   property p_ro_bit;
      regReq.rdEn && regReq.addr == 8'h3b |=> regRdData[0] == 1'b0;
   endproperty
   a_ro_bit: assert property (p_ro_bit) else $error("read-only bit not zero");

   property p_m_write;
      regReq.wrEn && regReq.addr == 8'h3a && regReq.wrData[7:2] != 6'h00
         && !autoDetectEn ##1 !autoDetectEn
         |=> divCfg.m_divider == {1'b0, $past(regReq.wrData[7:2], 2)};
   endproperty
   a_m_write: assert property (p_m_write) else $error("M write not applied");

   property p_enable;
      !nDividerEnable |=> !nDividerActive;
   endproperty
   a_enable: assert property (p_enable) else $error("N divider active while off");

endmodule

// ==== bench/ckd_host_model.sv ====
// Host software model driving the clock configuration control port
`timescale 1ns/10ps
module ckd_host_model
   import ckd_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic [7:0]   regRdData,
   output      ckd_reg_req_t regReq
);
   // ---------------------------------------------------------------
   // Port idle at time zero
   // ---------------------------------------------------------------
   initial regReq = '0;

   // Write one register; reserved bits held at reset value unless raw
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw,
                     output logic [7:0] sent);
      logic [7:0] m;
      m = 8'hff;
      if (!raw && (a == 8'h39 || a == 8'h3a))
         m = 8'hfc;                                   // Low pair written as zero
      if (!raw && a == 8'h3b)
         m = 8'h36;                                   // Bits 7:6, 3, 0 written as zero
      sent = d & m;
      @(posedge ref_clk);
      regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: sent};
      @(posedge ref_clk);
      // Released lines show the inverse so a stale value cannot pass
      regReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~sent};
   endtask

   // Read one register; data taken once the registered answer settles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h5a};
      @(posedge ref_clk);
      regReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: 8'ha5};
      @(posedge ref_clk);
      #1 d = regRdData;
   endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the clock configuration block
`timescale 1ns/10ps
module tb
   import ckd_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic         ref_clk;                  // 10 MHz clock
   logic         rst_n;                    // Async reset, low
   ckd_reg_req_t regReq;                   // From host model
   logic [7:0]   regRdData;                // Read answer
   logic         pllIntMultTopBit;         // Multiplier top bit
   logic         autoDetectEn;             // Auto detection on
   ckd_div_cfg_t autoCfg;                  // Auto settings
   ckd_div_cfg_t divCfg;                   // Decoded settings
   logic         nDividerEnable;
   logic         mDividerEnable;
   logic         densityModDividerEnable;
   logic         secondaryBitclkDivTop;
   logic         nDividerActive;
   logic         mDividerActive;
   logic         densityDividerActive;
   logic         reservedCodeSeen;
   logic [7:0]   mir [5];                  // Reference copy of the five registers
   logic [7:0]   rdv;                      // Last read value
   int           n_errors;
   int           n_tests;
   int           seed;
   int           cycleCount;               // Hang guard

   // ---------------------------------------------------------------
   // Instances
   // ---------------------------------------------------------------
   ckd_host_model i_ckd_host_model (.ref_clk(ref_clk), .regRdData(regRdData), .regReq(regReq));

   ckd_clock_cfg i_ckd_clock_cfg (
      .ref_clk(ref_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
      .pllIntMultTopBit(pllIntMultTopBit), .autoDetectEn(autoDetectEn), .autoCfg(autoCfg),
      .nDividerEnable(nDividerEnable), .mDividerEnable(mDividerEnable),
      .densityModDividerEnable(densityModDividerEnable), .divCfg(divCfg),
      .secondaryBitclkDivTop(secondaryBitclkDivTop), .nDividerActive(nDividerActive),
      .mDividerActive(mDividerActive), .densityDividerActive(densityDividerActive),
      .reservedCodeSeen(reservedCodeSeen));

   // Clock and hang guard; limit is many times the expected run
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 20000)
      begin
         n_errors++;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // Reference decode and comparison helpers
   // ---------------------------------------------------------------
   function automatic ckd_div_cfg_t model_cfg();
      ckd_div_cfg_t c;
      int           p;
      int           md;
      int           b;
      p = mir[1][4:2];
      md = mir[3][5:4];
      b = {mir[3][2], mir[4]};
      c.pllMult = {pllIntMultTopBit, mir[0]};
      c.n_divider = (mir[1][7:5] == 0) ? 4'h8 : 4'(mir[1][7:5]);
      c.densityDiv = (p > 4) ? 5'h01 : 5'(1 << p);
      c.m_divider = (mir[2][7:2] == 0) ? 7'h40 : 7'(mir[2][7:2]);
      c.modDiv = (md == 3) ? 3'h1 : 3'(1 << md);
      c.priBitclkDiv = (b == 0) ? 10'h200 : 10'(b);
      return autoDetectEn ? autoCfg : c;
   endfunction

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic check_all();
      chk("divCfg", divCfg, model_cfg());
      chk("rsvd", reservedCodeSeen, !autoDetectEn && ({pllIntMultTopBit, mir[0]} == 0
          || mir[1][4:2] > 4 || mir[3][5:4] == 3));
      chk("secTop", secondaryBitclkDivTop, mir[3][1]);
      chk("act", {nDividerActive, mDividerActive, densityDividerActive},
          {nDividerEnable, mDividerEnable, densityModDividerEnable});
   endtask

   task automatic rdchk(input int i);
      i_ckd_host_model.rd(8'h38 + 8'(i), rdv);
      chk("readback", rdv, mir[i]);
   endtask

   // Write, check nothing moves early, then check the new decode
   task automatic wset(input logic [7:0] a, input logic [7:0] d, input bit raw, input bit t);
      ckd_div_cfg_t old;
      logic [7:0]   s;
      @(posedge ref_clk);
      pllIntMultTopBit <= t;
      i_ckd_host_model.wr(a, d, raw, s);
      old = model_cfg();
      // Write edge just passed: outputs still show the settings from before it
      #1 chk("noEarly", divCfg, old);
      if (a >= 8'h38 && a <= 8'h3c)
         mir[a - 8'h38] = (a == 8'h3b) ? (s & 8'hfe) : s;
      @(posedge ref_clk);
      #1 check_all();
   endtask

   // Reset, then table reset values and decoded reset settings
   task automatic reset_check();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      mir = '{8'h08, 8'h20, 8'h04, 8'h00, 8'h01};
      repeat (2) @(posedge ref_clk);
      #1 check_all();
      for (int i = 0; i < 5; i++)
         rdchk(i);
      $display("test reset done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      pllIntMultTopBit = 1'b0;
      autoDetectEn = 1'b0;
      autoCfg = '0;
      {nDividerEnable, mDividerEnable, densityModDividerEnable} = 3'h0;
      n_errors = 0;
      n_tests = 0;
      seed = 98;
      cycleCount = 0;
      reset_check();
      // Every N and density code, reserved density codes included
      for (int i = 0; i < 8; i++)
      begin
         wset(8'h39, 8'((i << 5) | (i << 2)), 1'b0, 1'b0);
         rdchk(1);
      end
      // Modulator codes, zero and top boundaries of multiplier and M, and bit-clock codes 256 and 511
      for (int i = 0; i < 4; i++)
         wset(8'h3b, 8'((i << 4) | (i[0] << 2)), 1'b0, i[1]);
      wset(8'h38, 8'h00, 1'b0, 1'b0);
      wset(8'h38, 8'hff, 1'b0, 1'b1);
      wset(8'h3a, 8'h00, 1'b0, 1'b1);
      wset(8'h3a, 8'hfc, 1'b0, 1'b1);
      wset(8'h3c, 8'h00, 1'b0, 1'b0);
      wset(8'h3b, 8'h04, 1'b0, 1'b0);
      wset(8'h3c, 8'hff, 1'b0, 1'b0);
      $display("test boundaries done");
      // Read-only bit together with raw reserved bits, then unmapped offset
      wset(8'h3b, 8'hff, 1'b1, 1'b0);
      rdchk(3);
      wset(8'h40, 8'haa, 1'b1, 1'b0);
      i_ckd_host_model.rd(8'h40, rdv);
      chk("unmapped", rdv, 8'h00);
      for (int i = 0; i < 5; i++)
         rdchk(i);
      wset(8'h3b, 8'h00, 1'b0, 1'b0);
      $display("test refusals done");
      // Random traffic with random enables and auto detection
      for (int i = 0; i < 60; i++)
      begin
         @(posedge ref_clk);
         {nDividerEnable, mDividerEnable, densityModDividerEnable} <= 3'($random(seed));
         autoDetectEn <= (i % 4 == 3);
         autoCfg <= ckd_div_cfg_t'(38'({$random(seed), $random(seed)}));
         wset(8'h38 + 8'($unsigned($random(seed)) % 5), 8'($random(seed)), 1'b0,
              1'($random(seed)));
         rdchk(i % 5);
      end
      $display("test random done");
      reset_check();
      complete_run();
   end
endmodule
